// ---- bench/serd_link_properties.sv ----
// Checker on the two-wire link between controller and memory ends
`timescale 1ns/1ns
module serd_link_props
  import serd_pkg::*;
#(
  parameter logic [2:0] SEL = 3'h0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Link drivers and resolved wires
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_ctl_out,
  input wire logic sda_ctl_oe,
  input wire logic sda_mem_out,
  input wire logic sda_mem_oe,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_cnt;
  logic [1:0] byte_no;
  logic [7:0] shift;
  logic       rd_dir;
  logic       rd_live;
  wire        start = scl & scl_q & sda_q & ~sda;
  wire        stop  = scl & scl_q & ~sda_q & sda;
  wire        rise  = scl & ~scl_q;
  wire        hit   = (shift[7:1] == {DEV_PATTERN, SEL});

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // Byte framing seen on the wire; saturates so long reads stay in data phase
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt <= 4'h0;
      byte_no <= 2'h0;
      shift   <= 8'h00;
      rd_dir  <= 1'b0;
      rd_live <= 1'b0;
    end else if (start) begin
      bit_cnt <= 4'h0;
      byte_no <= 2'h0;
      rd_dir  <= 1'b0;
      rd_live <= 1'b0;
    end else if (rise && bit_cnt == 4'h8) begin
      bit_cnt <= 4'h0;
      // A read goes on only while each ninth clock carries an acknowledge
      rd_live <= rd_dir & ~sda;
      if (byte_no != 2'h3) begin
        byte_no <= byte_no + 2'h1;
      end
    end else if (rise) begin
      bit_cnt <= bit_cnt + 4'h1;
      shift   <= {shift[6:0], sda};
      if (byte_no == 2'h0 && bit_cnt == 4'h7) begin
        rd_dir <= sda;
      end
    end
  end

  dev_ack_a: assert property (
    rise && bit_cnt == 4'h8 && byte_no == 2'h0 |-> sda_mem_oe == hit)
    else $error("device address acknowledge wrong");
  mem_change_low_a: assert property (
    $changed(sda_mem_oe) |-> !scl) else $error("memory changed data with clock high");
  no_contention_a: assert property (
    scl |-> !(sda_mem_oe && sda_ctl_oe)) else $error("both ends pull data while clock high");
  ctl_release_a: assert property (
    rise && rd_live && bit_cnt != 4'h8 |-> !sda_ctl_oe)
    else $error("controller drove data during read byte");
  restart_free_a: assert property (
    start |-> !sda_mem_oe) else $error("memory held data at start");
  stop_free_a: assert property (
    stop |-> !sda_mem_oe) else $error("memory held data at stop");
  stop_quiet_a: assert property (
    stop |=> !sda_mem_oe [*8]) else $error("memory drove data after stop");
  scl_idle_a: assert property (
    stop |=> scl [*2]) else $error("clock moved right after stop");
endmodule : serd_link_props

// ---- bench/serial_eeprom_read_sequencer_tb.sv ----
// Self-checking bench: controller end reads the memory end across the link
`timescale 1ns/1ns
module serial_eeprom_read_sequencer_tb;
  import serd_pkg::*;
  localparam logic [2:0] STRAPS = 3'h5;
  localparam int         LIMIT  = 60000;
  logic         clock      = 1'b0;
  logic         arst_n     = 1'b0;
  logic         load_en    = 1'b0;
  logic [7:0]   load_addr  = 8'h00;
  logic [7:0]   load_data  = 8'h00;
  logic         busy;
  logic         req_valid  = 1'b0;
  logic         req_ready;
  serd_cmd_type req_cmd    = SERD_CMD_RANDOM;
  logic [2:0]   req_select = 3'h0;
  logic [7:0]   req_addr   = 8'h00;
  logic [8:0]   req_count  = 9'h001;
  logic [7:0]   rd_data;
  logic         rd_valid;
  logic         rd_ready   = 1'b0;
  logic         nack_err;
  logic [7:0]   image [256];
  logic [7:0]   ptr        = ADDR_RESET;
  logic [15:0]  lfsr       = 16'h6c6b;
  int           err_total  = 0;
  int           compares   = 0;
  int           cycles     = 0;

  serd_link_if link ();
  always #10 clock = ~clock;

  serd_mem_end serd_mem_end_i (.clock(clock), .arst_n(arst_n), .link(link),
    .chip_select_straps(STRAPS), .load_en(load_en), .load_addr(load_addr),
    .load_data(load_data), .busy(busy));
  serd_ctl_end serd_ctl_end_i (.clock(clock), .arst_n(arst_n), .link(link),
    .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd), .req_select(req_select),
    .req_addr(req_addr), .req_count(req_count), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .nack_err(nack_err));
  serd_link_props #(.SEL(STRAPS)) serd_link_props_i (.clock(clock), .arst_n(arst_n),
    .scl_out(link.scl_out), .scl_oe(link.scl_oe), .sda_ctl_out(link.sda_ctl_out),
    .sda_ctl_oe(link.sda_ctl_oe), .sda_mem_out(link.sda_mem_out),
    .sda_mem_oe(link.sda_mem_oe), .scl(link.scl), .sda(link.sda));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // Current-address reads start where the last read left off
  function automatic logic [7:0] first_addr(input serd_cmd_type cmd, input logic [7:0] a);
    return (cmd == SERD_CMD_RANDOM) ? a : ptr;
  endfunction : first_addr

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  localparam int W_READY = 0;
  localparam int W_DATA  = 1;
  localparam int W_BUSY  = 2;

  // Picks the watched output by number; avoids ref arguments on port-driven signals
  function automatic logic pick(input int which);
    return (which == W_READY) ? req_ready : (which == W_DATA) ? rd_valid : busy;
  endfunction : pick

  // Bounded wait, sampled one step after the edge so updates have landed
  task automatic wait_for(input int which, input logic val);
    int n;
    n = 0;
    while (pick(which) !== val && n < 5000) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (pick(which) !== val) begin
      err_total++;
      $display("CHECK FAILED wait %0d expected %b seen %b", which, val, pick(which));
    end
  endtask : wait_for

  task automatic run_read(input string name, input serd_cmd_type cmd, input logic [2:0] sel,
                          input logic [7:0] addr, input logic [8:0] count, input int stall);
    logic [7:0] a;
    logic       hit;
    hit = (sel == STRAPS);
    a = first_addr(cmd, addr);
    wait_for(W_READY, 1'b1);
    req_cmd = cmd;
    req_select = sel;
    req_addr = addr;
    req_count = count;
    req_valid = 1'b1;
    @(posedge clock);
    #1;
    req_valid = 1'b0;
    // Holding the drain on a read of ten or more bytes lets the buffer fill so the controller must stall the clock
    repeat (stall) @(posedge clock);
    #1;
    for (int i = 0; hit && i < count; i++) begin
      wait_for(W_DATA, 1'b1);
      check("read data", image[a], rd_data);
      a = a + 8'h01;
      rd_ready = 1'b1;
      @(posedge clock);
      #1;
      rd_ready = 1'b0;
    end
    wait_for(W_READY, 1'b1);
    wait_for(W_BUSY, 1'b0);
    if (hit) begin
      ptr = a;
    end
    check("nack flag", {7'h00, !hit}, {7'h00, nack_err});
    check("no extra byte", 8'h00, {7'h00, rd_valid});
    check("memory idle", 8'h00, {7'h00, busy});
    $display("test %s done", name);
  endtask : run_read

  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    for (int i = 0; i < 256; i++) begin
      lfsr = lfsr_next(lfsr);
      image[i] = lfsr[7:0];
    end
    repeat (10) @(posedge clock);
    #1;
    arst_n = 1'b1;
    for (int i = 0; i < 256; i++) begin
      load_en = 1'b1;
      load_addr = i[7:0];
      load_data = image[i];
      @(posedge clock);
      #1;
    end
    load_en = 1'b0;
    run_read("current after reset", SERD_CMD_CURRENT, STRAPS, 8'h00, 9'h002, 0);
    run_read("random single", SERD_CMD_RANDOM, STRAPS, 8'h5a, 9'h001, 0);
    run_read("wrap at top", SERD_CMD_RANDOM, STRAPS, 8'hfd, 9'h005, 0);
    run_read("current sequential", SERD_CMD_CURRENT, STRAPS, 8'h00, 9'h003, 0);
    run_read("wrong select random", SERD_CMD_RANDOM, ~STRAPS, 8'h33, 9'h002, 0);
    run_read("wrong select current", SERD_CMD_CURRENT, 3'h4, 8'h00, 9'h001, 0);
    run_read("after refusal", SERD_CMD_CURRENT, STRAPS, 8'h00, 9'h001, 0);
    run_read("buffer full", SERD_CMD_RANDOM, STRAPS, 8'h10, 9'h00c, 3000);
    for (int k = 0; k < 8; k++) begin
      lfsr = lfsr_next(lfsr);
      run_read("random mix", lfsr[0] ? SERD_CMD_CURRENT : SERD_CMD_RANDOM,
               lfsr[13] ? lfsr[10:8] : STRAPS, lfsr[7:0], {7'h00, lfsr[2:1]} + 9'h001,
               lfsr[3] ? 400 : 0);
    end
    end_of_test();
  end
endmodule : serial_eeprom_read_sequencer_tb

// ---- rtl/serd_ctl_end.sv ----
// Controller end: issues random or current-address sequential reads
`timescale 1ns/1ns
module serd_ctl_end
  import serd_pkg::*;
#(
  parameter int HALF = HALF_CYCLES
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         arst_n,
  // Link
  serd_link_if.ctl          link,
  // Request
  input  wire logic         req_valid,
  output logic              req_ready,
  input  serd_pkg::serd_cmd_type req_cmd,
  input  wire logic [2:0]   req_select,
  input  wire logic [7:0]   req_addr,
  input  wire logic [8:0]   req_count,
  // Read data
  output logic [7:0]        rd_data,
  output logic              rd_valid,
  input  wire logic         rd_ready,
  // Status
  output logic              nack_err
);
  initial begin
    if (HALF < 1) $error("half period must be at least one cycle");
  end
  typedef enum logic [3:0] {
    C_IDLE, C_START, C_BYTE, C_ACK, C_RBYTE, C_MACK, C_RESTART, C_STOP, C_DONE
  } serd_ctl_state_type;
  serd_ctl_state_type state;
  logic [15:0] tmr;
  logic [1:0]  phase;
  logic [7:0]  tx;
  logic [7:0]  rx;
  logic [3:0]  bits;
  logic [8:0]  left;
  logic        stage;
  logic [2:0]  sel;
  logic [7:0]  waddr;
  logic [1:0]  sda_sync;
  logic        tick;
  logic        f_valid;
  logic        f_ready;
  logic        scl_o;
  logic        sda_o;
  assign tick = tmr == 16'(HALF - 1);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sda_sync <= 2'h3;
    end else begin
      sda_sync <= {sda_sync[0], link.sda};
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tmr <= '0;
    end else begin
      tmr <= (tick || state == C_IDLE) ? 16'h0000 : tmr + 16'h0001;
    end
  end
  // Phases per bit: 0 low setup, 1 rise, 2 high sample, 3 fall
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= C_IDLE; phase <= '0; tx <= '0; rx <= '0; bits <= '0;
      left <= '0; stage <= 1'b0; sel <= '0; waddr <= '0;
      scl_o <= 1'b1; sda_o <= 1'b1; f_valid <= 1'b0; nack_err <= 1'b0;
    end else begin
      if (f_ready) f_valid <= 1'b0;
      if (state == C_IDLE) begin
        if (req_valid) begin
          sel   <= req_select;
          // All ones marks the restart step, so a current read carries no address
          waddr <= (req_cmd == SERD_CMD_RANDOM) ? req_addr : 8'h00;
          left  <= req_count;
          stage <= req_cmd == SERD_CMD_RANDOM;
          nack_err <= 1'b0;
          phase <= '0;
          state <= C_START;
        end
      end else if (tick && !(state == C_RBYTE && phase == 2'h0 && bits == 4'h0
                             && f_valid)) begin
        phase <= phase + 2'h1;
        unique case (state)
          C_START, C_RESTART: begin
            unique case (phase)
              2'h0: begin sda_o <= 1'b1; scl_o <= 1'b0; end
              2'h1: scl_o <= 1'b1;
              2'h2: sda_o <= 1'b0;
              2'h3: begin
                scl_o <= 1'b0;
                tx    <= {DEV_PATTERN, sel, ~stage};
                bits  <= '0;
                state <= C_BYTE;
              end
            endcase
          end
          C_BYTE, C_RBYTE, C_ACK, C_MACK: begin
            unique case (phase)
              2'h0: begin
                if (state == C_BYTE) sda_o <= tx[7];
                else if (state == C_MACK) sda_o <= left == 9'h001;
                else sda_o <= 1'b1;
              end
              2'h1: scl_o <= 1'b1;
              2'h2: begin
                // Only read bits shift in; a byte held for a full queue must survive
                if (state == C_RBYTE) begin
                  rx <= {rx[6:0], sda_sync[1]};
                end
                if (state == C_ACK && sda_sync[1]) nack_err <= 1'b1;
              end
              2'h3: begin
                scl_o <= 1'b0;
                tx    <= {tx[6:0], 1'b0};
                bits  <= bits + 4'h1;
                if ((state == C_BYTE || state == C_RBYTE) && bits == 4'h7) begin
                  state <= (state == C_BYTE) ? C_ACK : C_MACK;
                  if (state == C_RBYTE) f_valid <= 1'b1;
                end else if (state == C_ACK) begin
                  bits <= '0;
                  if (nack_err) state <= C_STOP;
                  else if (stage && tx == 8'h00 && rx[0] == 1'b0 && waddr != 8'hff
                           && bits == 4'h8) state <= C_BYTE;
                  else state <= C_BYTE;
                  if (stage && tx == 8'h00 && bits == 4'h8 && !nack_err) begin
                    // Device address done: send word address next, or read
                    tx    <= waddr;
                    stage <= 1'b0;
                    waddr <= 8'hff;
                  end else if (!stage && waddr == 8'hff && !nack_err) begin
                    state <= C_RESTART;
                    waddr <= 8'h00;
                  end else if (!nack_err) begin
                    state <= C_RBYTE;
                  end
                end else if (state == C_MACK) begin
                  bits  <= '0;
                  left  <= left - 9'h001;
                  state <= (left == 9'h001) ? C_STOP : C_RBYTE;
                end
              end
            endcase
          end
          C_STOP: begin
            unique case (phase)
              2'h0: sda_o <= 1'b0;
              2'h1: scl_o <= 1'b1;
              2'h2: sda_o <= 1'b1;
              2'h3: state <= C_DONE;
            endcase
          end
          C_DONE: state <= C_IDLE;
          default: state <= C_IDLE;
        endcase
      end
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= state == C_IDLE && !req_valid;
    end
  end
  // Read bytes queue here; with the queue full the next byte is still held in rx, and the bus clock stalls before the byte after it
  serd_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .arst_n    (arst_n),
    .in_data   (rx),
    .in_valid  (f_valid),
    .in_ready  (f_ready),
    .out_data  (rd_data),
    .out_valid (rd_valid),
    .out_ready (rd_ready)
  );
  assign link.scl_out     = scl_o;
  assign link.scl_oe      = ~scl_o;
  assign link.sda_ctl_out = sda_o;
  assign link.sda_ctl_oe  = ~sda_o;
endmodule : serd_ctl_end

// ---- rtl/serd_fifo.sv ----
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ns
module serd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             arst_n,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;
  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : serd_fifo

// ---- rtl/serd_link_if.sv ----
// Two-wire link between controller and memory ends
`timescale 1ns/1ns
interface serd_link_if;
  logic scl_out;
  logic scl_oe;
  logic sda_ctl_out;
  logic sda_ctl_oe;
  logic sda_mem_out;
  logic sda_mem_oe;
  wire  scl = ~(scl_oe & ~scl_out);
  wire  sda = ~((sda_ctl_oe & ~sda_ctl_out) | (sda_mem_oe & ~sda_mem_out));
  modport mem  (input scl, input sda, output sda_mem_out, output sda_mem_oe);
  modport ctl  (input scl, input sda, output scl_out, output scl_oe,
                output sda_ctl_out, output sda_ctl_oe);
endinterface : serd_link_if

// ---- rtl/serd_mem_end.sv ----
// Memory end: two-wire target answering random, current and sequential reads
// Behaviour
// - Controller dummy-writes word address first
// - Repeated start follows acknowledged word address
// - Device address resent with read direction
// - Acknowledge read address, then output byte
// - Single read ends with no-ack, stop
// - Sequential read starts like other reads
// - Controller acknowledges to request more bytes
// - Acknowledge advances address, next byte follows
// - Address wraps from top to zero
// - No-ack then stop ends read, release line
// - Match 1010, straps; mismatch goes standby
// - Eight-bit words, ninth clock acknowledge
// - Address counter kept, last plus one
// - 256 bytes, wrap last to first
`timescale 1ns/1ns
module serd_mem_end
  import serd_pkg::*;
#(
  parameter int DEPTH = 256
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         arst_n,
  // Link
  serd_link_if.mem          link,
  // Strap pins and array load port
  input  wire logic [2:0]   chip_select_straps,
  input  wire logic         load_en,
  input  wire logic [7:0]   load_addr,
  input  wire logic [7:0]   load_data,
  // Status
  output logic              busy
);
  initial begin
    if (DEPTH != (1 << ADDR_W)) $error("depth must match the word address width");
  end
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEV, ST_DEV_ACK, ST_WADDR, ST_WADDR_ACK, ST_SEND, ST_HOST_ACK
  } serd_mem_state_type;
  serd_mem_state_type state;
  logic [7:0] array [DEPTH];
  logic [7:0] addr;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic       rd_dir;
  logic [2:0] straps_meta;
  logic [2:0] straps;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_q;
  logic       sda_q;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic       sda_out;
  logic       sda_oe;
  logic [7:0] rx_byte;
  // Pins pass two flops; only the second stage and later are read
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
    end
  end
  // Straps are pins too: two flops before the address compare reads them
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      straps_meta <= SEL_RESET;
      straps      <= SEL_RESET;
    end else begin
      straps_meta <= chip_select_straps;
      straps      <= straps_meta;
    end
  end
  assign scl_rise   = scl_sync[1] & ~scl_q;
  assign scl_fall   = ~scl_sync[1] & scl_q;
  assign start_seen = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
  assign stop_seen  = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
  assign rx_byte    = {shreg[6:0], sda_sync[1]};
  // Array load port lets the bench fill contents; the read path never writes
  always_ff @(posedge clock) begin
    if (load_en) begin
      array[load_addr] <= load_data;
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state   <= ST_IDLE;
      addr    <= ADDR_RESET;
      shreg   <= '0;
      bitcnt  <= '0;
      rd_dir  <= 1'b0;
      sda_out <= 1'b1;
      sda_oe  <= 1'b0;
    end else if (stop_seen) begin
      state  <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (start_seen) begin
      state  <= ST_DEV;
      bitcnt <= '0;
      sda_oe <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        ST_DEV, ST_WADDR: begin
          if (scl_rise) begin
            shreg  <= rx_byte;
            bitcnt <= bitcnt + 4'h1;
          end
          if (scl_fall && bitcnt == 4'h8) begin
            bitcnt <= '0;
            if (state == ST_WADDR) begin
              addr    <= shreg;
              state   <= ST_WADDR_ACK;
              sda_out <= 1'b0;
              sda_oe  <= 1'b1;
            end else if (shreg[7:DEV_PAT_POS] == DEV_PATTERN &&
                         shreg[DEV_SEL_POS +: 3] == straps) begin
              rd_dir  <= shreg[DEV_DIR_POS];
              state   <= ST_DEV_ACK;
              sda_out <= 1'b0;
              sda_oe  <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_DEV_ACK, ST_WADDR_ACK: begin
          if (scl_fall) begin
            if (state == ST_DEV_ACK && rd_dir) begin
              shreg   <= {array[addr][6:0], 1'b0};
              sda_out <= array[addr][7];
              sda_oe  <= 1'b1;
              addr    <= addr + 8'h01;
              bitcnt  <= 4'h1;
              state   <= ST_SEND;
            end else begin
              // Write direction takes the word address next; data after it is out of scope, so wait for the repeated start
              sda_oe <= 1'b0;
              state  <= (state == ST_DEV_ACK) ? ST_WADDR : ST_IDLE;
            end
          end
        end
        ST_SEND: begin
          if (scl_fall) begin
            if (bitcnt == 4'h8) begin
              sda_oe <= 1'b0;
              state  <= ST_HOST_ACK;
            end else begin
              sda_out <= shreg[7];
              shreg   <= {shreg[6:0], 1'b0};
              bitcnt  <= bitcnt + 4'h1;
            end
          end
        end
        ST_HOST_ACK: begin
          if (scl_rise) begin
            rd_dir <= ~sda_sync[1];
          end
          if (scl_fall) begin
            if (rd_dir) begin
              shreg   <= {array[addr][6:0], 1'b0};
              sda_out <= array[addr][7];
              sda_oe  <= 1'b1;
              addr    <= addr + 8'h01;
              bitcnt  <= 4'h1;
              state   <= ST_SEND;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= state != ST_IDLE;
    end
  end
  assign link.sda_mem_out = sda_out;
  assign link.sda_mem_oe  = sda_oe & ~sda_out;
endmodule : serd_mem_end

// ---- rtl/serd_pkg.sv ----
// Shared constants and types for the serial memory read sequencer
package serd_pkg;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 8;
  localparam logic [3:0]  DEV_PATTERN    = 4'ha;
  localparam int          DEV_PAT_POS    = 4;
  localparam int          DEV_SEL_POS    = 1;
  localparam int          DEV_DIR_POS    = 0;
  localparam logic [7:0]  ADDR_RESET     = 8'h00;
  localparam logic [2:0]  SEL_RESET      = 3'h0;
  localparam int          CLK_MHZ        = 50;
  localparam int          LINK_PERIOD_NS = 160;
  localparam int          HALF_NS        = LINK_PERIOD_NS / 2;
  localparam int          HALF_CYCLES    = (HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int          FIFO_DEPTH     = 8;
  typedef enum logic [1:0] {
    SERD_CMD_CURRENT,
    SERD_CMD_RANDOM
  } serd_cmd_type;
endpackage : serd_pkg
